// ==== pkg/cpu8_decode_consts.svh ====
/*
 Opcode patterns, field positions, flag positions and cycle costs of the
 8-bit opcode decoder.
 Assumes one decoder clock per processor clock cycle.
*/
`ifndef CPU8_DECODE_CONSTS_SVH
`define CPU8_DECODE_CONSTS_SVH

// ==========================================================
// opcode fields
`define SRC_FLD       2:0
`define PAIR_FLD      5:4
`define VEC_FLD       5:3
`define COND_KIND     5:4
`define COND_SENSE    3
`define VEC_PAD       3'h0

// ==========================================================
// single opcodes
`define OPC_SWAP      8'hE3
`define OPC_LDSP      8'hF9
`define OPC_SUBI      8'hD6
`define OPC_XORI      8'hEE
`define OPC_ANDI      8'hE6
`define OPC_ROTL      8'h17
`define OPC_ROTR      8'h1F
`define OPC_RET_PE    8'hE8
`define OPC_RET_PO    8'hE0
`define OPC_HALT      8'h76
`define OPC_INT_ON    8'hFB
`define OPC_INT_OFF   8'hF3
`define OPC_NOP       8'h00

// ==========================================================
// opcode groups
`define MASK_ALU      8'hF8
`define ALU_ADC       8'h88
`define ALU_SBB       8'h98
`define ALU_AND       8'hA0
`define ALU_XOR       8'hA8
`define ALU_CMPR      8'hB8
`define MASK_PAIR     8'hCF
`define PAT_PAIR_ADD  8'h09
`define PAT_PAIR_INC  8'h03
`define PAT_PAIR_DEC  8'h0B
`define MASK_VEC      8'hC7
`define PAT_RESTART   8'hC7
`define PAT_RET_COND  8'hC0

// ==========================================================
// flags and data bits
`define FLG_S         7
`define FLG_Z         6
`define FLG_AC        4
`define FLG_P         2
`define FLG_CY        0
`define FLAGS_NO_CY   8'hFE
`define BYTE_MSB      7
`define BYTE_LSB      0
`define LOW7          6:0
`define HIGH7         7:1
`define LO_NIB        3:0
`define NIB_CARRY     4
`define BYTE_CARRY    8
`define WORD_CARRY    16
`define SYNC_LAST     1
`define STACK_STEP    16'h0002
`define PAIR_STEP     16'h0001
`define CNT_STEP      5'h01

// ==========================================================
// cycle costs
`define CYC_SHORT     5'h04
`define CYC_MEM       5'h07
`define CYC_RET_SKIP  5'h06
`define CYC_RET_TAKE  5'h0C
`define CYC_SWAP      5'h10
`define CYC_LDSP      5'h06
`define CYC_PAIR_ADD  5'h0A
`define CYC_RESTART   5'h0C
`define CYC_PAIR_STEP 5'h06
`define CYC_HALT      5'h05

`endif

// ==== pkg/cpu8_decode_pkg.sv ====
/*
 Types of the 8-bit opcode decoder: operation classes, register
 selects, register snapshot, decode result and decoder state.
 Assumes the consts header supplies all numeric values.
*/
package cpu8_decode_pkg;

   // ==========================================================
   // enumerations
   typedef enum logic [4:0] {
      op_none, op_ret_cond, op_swap_stack, op_load_sp, op_pair_add,
      op_add_carry, op_sub_borrow, op_sub_imm, op_xor, op_and,
      op_compare, op_rot_left, op_rot_right, op_restart, op_pair_inc,
      op_pair_dec, op_halt, op_int_on, op_int_off, op_nop
   } op_class_t;

   // declaration order gives the register field codes 000..111
   typedef enum logic [2:0] {
      sel_b, sel_c, sel_d, sel_e, sel_h, sel_l, sel_mem, sel_acc
   } reg_sel_t;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic [7:0]  acc;
      logic [7:0]  b;
      logic [7:0]  c;
      logic [7:0]  d;
      logic [7:0]  e;
      logic [7:0]  h;
      logic [7:0]  l;
      logic [7:0]  flags;
      logic [15:0] sp;
      logic [15:0] pc;
   } cpu_regs_t;

   typedef struct packed {
      op_class_t   op;
      reg_sel_t    src;
      logic [4:0]  cycles;
      logic        taken;
      logic        stack_wr;
      logic [15:0] stack_data;
      cpu_regs_t   regs;
   } decode_out_t;

   typedef struct packed {
      logic [1:0]  irq_sync;
      logic [4:0]  count;
      logic        halted;
      logic        int_en;
      logic        ready;
      logic        res_valid;
      decode_out_t res;
   } dec_state_t;

endpackage : cpu8_decode_pkg

// ==== rtl/cpu8_opcode_decode_timing.sv ====
/*
 Opcode decoder and cycle timer of an 8-bit processor core: decodes one
 opcode byte against a register snapshot, returns the updated registers
 and the cycle cost, and holds off the next opcode for that many cycles, or after a halt until an enabled interrupt.
 Assumes the fetch side presents the memory or immediate byte and the
 stack-top word together with the opcode; irq_pin is asynchronous.
*/
`timescale 1ns/1ps
`include "cpu8_decode_consts.svh"

// How it works
// - register field: B,C,D,E,H,L,memory,accumulator
// - conditional return costs 6 skipped, 12 taken
// - parity returns E8/E0 pop only on match
// - E3 swaps pair with stack top, 16
// - F9 copies pair to stack pointer, 6
// - pair add to H/L, carry only, 10
// - add register with carry, 4 cycles
// - memory operand arithmetic takes 7 cycles
// - subtract register with borrow, 4 cycles
// - D6 subtracts immediate byte, 7 cycles
// - xor register into accumulator, 4 cycles
// - EE xor, E6 and immediate, 7
// - and immediate distinct from and register
// - compare sets flags, accumulator kept, 4
// - compare memory operand takes 7 cycles
// - 17 rotates left through carry, 4
// - 1F rotates right through carry, 4
module cpu8_opcode_decode_timing (
   input  wire logic                         mclk,
   input  wire logic                         rst,
   input  wire logic                         irq_pin,
   input  wire logic                         op_valid,
   input  wire logic [7:0]                   op_byte,
   input  wire cpu8_decode_pkg::cpu_regs_t   cur,
   input  wire logic [7:0]                   data_byte,
   input  wire logic [15:0]                  stack_word,
   output logic                              op_ready,
   output logic                              res_valid,
   output cpu8_decode_pkg::decode_out_t      res,
   output logic                              halted
);

   // ==========================================================
   // state
   localparam cpu8_decode_pkg::dec_state_t RESET_STATE =
      '{ready: 1'b1, default: '0};

   cpu8_decode_pkg::dec_state_t s;
   cpu8_decode_pkg::dec_state_t next_s;
   logic                        accept;

   assign accept = op_valid & s.ready;

   // ==========================================================
   // helpers
   function automatic logic [7:0] szp(input logic [7:0] r,
                                      input logic       cy,
                                      input logic       ac);
      logic [7:0] f;
      f = '0;
      f[`FLG_S] = r[`BYTE_MSB];
      f[`FLG_Z] = (r == 8'h00);
      f[`FLG_P] = ~^r;
      f[`FLG_AC] = ac;
      f[`FLG_CY] = cy;
      return f;
   endfunction : szp

   // returns {carry or borrow, aux carry, result}
   function automatic logic [9:0] alu(input logic [7:0] a,
                                      input logic [7:0] b,
                                      input logic       ci,
                                      input logic       sub);
      logic [7:0] bb;
      logic       cc;
      logic [8:0] w;
      logic [4:0] nib;
      bb = sub ? ~b : b;
      cc = sub ? ~ci : ci;
      w = {1'b0, a} + {1'b0, bb} + {8'h00, cc};
      nib = {1'b0, a[`LO_NIB]} + {1'b0, bb[`LO_NIB]} + {4'h0, cc};
      return {w[`BYTE_CARRY] ^ sub, nib[`NIB_CARRY], w[`BYTE_MSB:0]};
   endfunction : alu

   function automatic logic [7:0] pick(
      input cpu8_decode_pkg::cpu_regs_t r,
      input cpu8_decode_pkg::reg_sel_t  sel,
      input logic [7:0]                 mem);
      logic [7:0] v;
      v = mem;
      unique case (sel)
         cpu8_decode_pkg::sel_b:   v = r.b;
         cpu8_decode_pkg::sel_c:   v = r.c;
         cpu8_decode_pkg::sel_d:   v = r.d;
         cpu8_decode_pkg::sel_e:   v = r.e;
         cpu8_decode_pkg::sel_h:   v = r.h;
         cpu8_decode_pkg::sel_l:   v = r.l;
         cpu8_decode_pkg::sel_mem: v = mem;
         cpu8_decode_pkg::sel_acc: v = r.acc;
      endcase
      return v;
   endfunction : pick

   function automatic cpu8_decode_pkg::cpu_regs_t set_pair(
      input cpu8_decode_pkg::cpu_regs_t r,
      input logic [1:0]                 p,
      input logic [15:0]                v);
      cpu8_decode_pkg::cpu_regs_t o;
      o = r;
      unique case (p)
         2'h0: {o.b, o.c} = v;
         2'h1: {o.d, o.e} = v;
         2'h2: {o.h, o.l} = v;
         2'h3: o.sp = v;
      endcase
      return o;
   endfunction : set_pair

   // ==========================================================
   // decode one opcode against the register snapshot
   function automatic cpu8_decode_pkg::decode_out_t decode(
      input logic [7:0]                 op,
      input cpu8_decode_pkg::cpu_regs_t r,
      input logic [7:0]                 mem,
      input logic [15:0]                stk);
      cpu8_decode_pkg::decode_out_t d;
      logic [7:0]  sv;
      logic [15:0] pv;
      logic [15:0] hl;
      logic [16:0] w;
      logic [9:0]  a;
      logic [4:0]  mem_cost;
      logic        cy;
      logic        fl;
      d = '0;
      d.regs = r;
      d.op = cpu8_decode_pkg::op_none;
      d.cycles = `CYC_SHORT;
      d.src = cpu8_decode_pkg::reg_sel_t'(op[`SRC_FLD]);
      sv = pick(r, d.src, mem);
      hl = {r.h, r.l};
      cy = r.flags[`FLG_CY];
      mem_cost = (d.src == cpu8_decode_pkg::sel_mem) ? `CYC_MEM
                                                     : `CYC_SHORT;
      unique case (op[`PAIR_FLD])
         2'h0: pv = {r.b, r.c};
         2'h1: pv = {r.d, r.e};
         2'h2: pv = hl;
         2'h3: pv = r.sp;
      endcase
      w = '0;
      a = '0;
      fl = 1'b0;
      if ((op & `MASK_ALU) == `ALU_ADC)
      begin
         a = alu(r.acc, sv, cy, 1'b0);
         d.op = cpu8_decode_pkg::op_add_carry;
         d.regs.acc = a[7:0];
         d.regs.flags = szp(a[7:0], a[9], a[8]);
         d.cycles = mem_cost;
      end
      else if ((op & `MASK_ALU) == `ALU_SBB)
      begin
         a = alu(r.acc, sv, cy, 1'b1);
         d.op = cpu8_decode_pkg::op_sub_borrow;
         d.regs.acc = a[7:0];
         d.regs.flags = szp(a[7:0], a[9], a[8]);
         d.cycles = mem_cost;
      end
      else if ((op & `MASK_ALU) == `ALU_XOR)
      begin
         d.op = cpu8_decode_pkg::op_xor;
         d.regs.acc = r.acc ^ sv;
         d.regs.flags = szp(r.acc ^ sv, 1'b0, 1'b0);
         d.cycles = mem_cost;
      end
      else if ((op & `MASK_ALU) == `ALU_AND)
      begin
         d.op = cpu8_decode_pkg::op_and;
         d.regs.acc = r.acc & sv;
         d.regs.flags = szp(r.acc & sv, 1'b0, 1'b1);
         d.cycles = mem_cost;
      end
      else if ((op & `MASK_ALU) == `ALU_CMPR)
      begin
         a = alu(r.acc, sv, 1'b0, 1'b1);
         d.op = cpu8_decode_pkg::op_compare;
         d.regs.flags = szp(a[7:0], a[9], a[8]);
         d.cycles = mem_cost;
      end
      else if (op == `OPC_SUBI)
      begin
         a = alu(r.acc, mem, 1'b0, 1'b1);
         d.op = cpu8_decode_pkg::op_sub_imm;
         d.regs.acc = a[7:0];
         d.regs.flags = szp(a[7:0], a[9], a[8]);
         d.cycles = `CYC_MEM;
      end
      else if (op == `OPC_XORI)
      begin
         d.op = cpu8_decode_pkg::op_xor;
         d.regs.acc = r.acc ^ mem;
         d.regs.flags = szp(r.acc ^ mem, 1'b0, 1'b0);
         d.cycles = `CYC_MEM;
      end
      else if (op == `OPC_ANDI)
      begin
         d.op = cpu8_decode_pkg::op_and;
         d.regs.acc = r.acc & mem;
         d.regs.flags = szp(r.acc & mem, 1'b0, 1'b1);
         d.cycles = `CYC_MEM;
      end
      else if (op == `OPC_ROTL)
      begin
         d.op = cpu8_decode_pkg::op_rot_left;
         d.regs.acc = {r.acc[`LOW7], cy};
         d.regs.flags[`FLG_CY] = r.acc[`BYTE_MSB];
      end
      else if (op == `OPC_ROTR)
      begin
         d.op = cpu8_decode_pkg::op_rot_right;
         d.regs.acc = {cy, r.acc[`HIGH7]};
         d.regs.flags[`FLG_CY] = r.acc[`BYTE_LSB];
      end
      else if (op == `OPC_SWAP)
      begin
         d.op = cpu8_decode_pkg::op_swap_stack;
         {d.regs.h, d.regs.l} = stk;
         d.stack_wr = 1'b1;
         d.stack_data = hl;
         d.cycles = `CYC_SWAP;
      end
      else if (op == `OPC_LDSP)
      begin
         d.op = cpu8_decode_pkg::op_load_sp;
         d.regs.sp = hl;
         d.cycles = `CYC_LDSP;
      end
      else if ((op & `MASK_PAIR) == `PAT_PAIR_ADD)
      begin
         w = {1'b0, hl} + {1'b0, pv};
         d.op = cpu8_decode_pkg::op_pair_add;
         {d.regs.h, d.regs.l} = w[15:0];
         d.regs.flags[`FLG_CY] = w[`WORD_CARRY];
         d.cycles = `CYC_PAIR_ADD;
      end
      else if ((op & `MASK_PAIR) == `PAT_PAIR_INC)
      begin
         d.op = cpu8_decode_pkg::op_pair_inc;
         d.regs = set_pair(r, op[`PAIR_FLD], pv + `PAIR_STEP);
         d.cycles = `CYC_PAIR_STEP;
      end
      else if ((op & `MASK_PAIR) == `PAT_PAIR_DEC)
      begin
         d.op = cpu8_decode_pkg::op_pair_dec;
         d.regs = set_pair(r, op[`PAIR_FLD], pv - `PAIR_STEP);
         d.cycles = `CYC_PAIR_STEP;
      end
      else if ((op & `MASK_VEC) == `PAT_RESTART)
      begin
         d.op = cpu8_decode_pkg::op_restart;
         d.stack_wr = 1'b1;
         d.stack_data = r.pc;
         d.regs.sp = r.sp - `STACK_STEP;
         d.regs.pc = 16'({op[`VEC_FLD], `VEC_PAD});
         d.cycles = `CYC_RESTART;
      end
      else if ((op & `MASK_VEC) == `PAT_RET_COND)
      begin
         unique case (op[`COND_KIND])
            2'h0: fl = r.flags[`FLG_Z];
            2'h1: fl = r.flags[`FLG_CY];
            2'h2: fl = r.flags[`FLG_P];
            2'h3: fl = r.flags[`FLG_S];
         endcase
         d.op = cpu8_decode_pkg::op_ret_cond;
         d.taken = (fl == op[`COND_SENSE]);
         d.cycles = d.taken ? `CYC_RET_TAKE : `CYC_RET_SKIP;
         if (d.taken)
         begin
            d.regs.pc = stk;
            d.regs.sp = r.sp + `STACK_STEP;
         end
      end
      else if (op == `OPC_HALT)
      begin
         d.op = cpu8_decode_pkg::op_halt;
         d.cycles = `CYC_HALT;
      end
      else if (op == `OPC_INT_ON)
         d.op = cpu8_decode_pkg::op_int_on;
      else if (op == `OPC_INT_OFF)
         d.op = cpu8_decode_pkg::op_int_off;
      else if (op == `OPC_NOP)
         d.op = cpu8_decode_pkg::op_nop;
      return d;
   endfunction : decode

   // ==========================================================
   // sequencing: cost countdown, halt and interrupt enable
   always_comb
   begin
      next_s = s;
      next_s.irq_sync = {s.irq_sync[0], irq_pin};
      next_s.res_valid = 1'b0;
      if (s.count != '0)
         next_s.count = s.count - `CNT_STEP;
      // an enabled interrupt releases the halt
      if (s.halted && s.irq_sync[`SYNC_LAST] && s.int_en)
         next_s.halted = 1'b0;
      if (accept)
      begin
         next_s.res = decode(op_byte, cur, data_byte, stack_word);
         next_s.res_valid = 1'b1;
         next_s.count = next_s.res.cycles - `CNT_STEP;
         if (next_s.res.op == cpu8_decode_pkg::op_halt)
            next_s.halted = 1'b1;
         if (next_s.res.op == cpu8_decode_pkg::op_int_on)
            next_s.int_en = 1'b1;
         if (next_s.res.op == cpu8_decode_pkg::op_int_off)
            next_s.int_en = 1'b0;
      end
      next_s.ready = (next_s.count == '0) && !next_s.halted;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         s <= RESET_STATE;
      else
         s <= next_s;
   end

   assign op_ready  = s.ready;
   assign res_valid = s.res_valid;
   assign res       = s.res;
   assign halted    = s.halted;

   // ==========================================================
   // checks
   a_reg_field_map: assert property (
      @(posedge mclk) disable iff (rst)
      accept |=> res.src == cpu8_decode_pkg::reg_sel_t'(
                           $past(op_byte[`SRC_FLD])))
      else $error("register field decoded wrongly");

   a_ret_taken_cost: assert property (
      @(posedge mclk) disable iff (rst)
      accept && op_byte == `OPC_RET_PO && !cur.flags[`FLG_P]
      |=> res.taken && res.cycles == `CYC_RET_TAKE
          && res.regs.sp == $past(cur.sp) + `STACK_STEP
          && !op_ready ##1 !op_ready [*7])
      else $error("taken return cost or pop wrong");

   a_ret_skip_keep: assert property (
      @(posedge mclk) disable iff (rst)
      accept && op_byte == `OPC_RET_PE && !cur.flags[`FLG_P]
      |=> !res.taken && res.cycles == `CYC_RET_SKIP
          && res.regs.pc == $past(cur.pc) ##5 op_ready)
      else $error("skipped return not six cycles");

   a_swap_stack_top: assert property (
      @(posedge mclk) disable iff (rst)
      accept && op_byte == `OPC_SWAP
      |=> res.stack_wr && res.cycles == `CYC_SWAP
          && {res.regs.h, res.regs.l} == $past(stack_word)
          && res.regs.sp == $past(cur.sp))
      else $error("swap with stack top wrong");

   a_sp_from_pair: assert property (
      @(posedge mclk) disable iff (rst)
      accept && op_byte == `OPC_LDSP
      |=> res.regs.sp == {$past(cur.h), $past(cur.l)}
          && res.cycles == `CYC_LDSP)
      else $error("stack pointer load wrong");

   a_pair_add_flags: assert property (
      @(posedge mclk) disable iff (rst)
      accept && (op_byte & `MASK_PAIR) == `PAT_PAIR_ADD
      |=> ((res.regs.flags ^ $past(cur.flags)) & `FLAGS_NO_CY) == 8'h00
          && res.cycles == `CYC_PAIR_ADD)
      else $error("pair add touched other flags");

   a_xor_reg_value: assert property (
      @(posedge mclk) disable iff (rst)
      accept && op_byte == `ALU_XOR
      |=> res.regs.acc == ($past(cur.acc) ^ $past(cur.b))
          && res.cycles == `CYC_SHORT)
      else $error("xor with register wrong");

   a_compare_keeps_acc: assert property (
      @(posedge mclk) disable iff (rst)
      accept && (op_byte & `MASK_ALU) == `ALU_CMPR
      |=> res.regs.acc == $past(cur.acc)
          && res.cycles == (res.src == cpu8_decode_pkg::sel_mem
                            ? `CYC_MEM : `CYC_SHORT))
      else $error("compare changed accumulator");

   a_rotate_left: assert property (
      @(posedge mclk) disable iff (rst)
      accept && op_byte == `OPC_ROTL
      |=> {res.regs.flags[`FLG_CY], res.regs.acc}
          == {$past(cur.acc), $past(cur.flags[`FLG_CY])})
      else $error("rotate left through carry wrong");

   a_rotate_right: assert property (
      @(posedge mclk) disable iff (rst)
      accept && op_byte == `OPC_ROTR
      |=> {res.regs.acc, res.regs.flags[`FLG_CY]}
          == {$past(cur.flags[`FLG_CY]), $past(cur.acc)})
      else $error("rotate right through carry wrong");

   a_restart_vector: assert property (
      @(posedge mclk) disable iff (rst)
      accept && (op_byte & `MASK_VEC) == `PAT_RESTART
      |=> res.regs.pc == 16'({$past(op_byte[`VEC_FLD]), `VEC_PAD})
          && res.stack_data == $past(cur.pc)
          && res.cycles == `CYC_RESTART)
      else $error("restart vector or push wrong");

   a_halt_stops_fetch: assert property (
      @(posedge mclk) disable iff (rst)
      accept && op_byte == `OPC_HALT
      |=> halted && !op_ready [*4])
      else $error("halt did not stop fetch");

endmodule : cpu8_opcode_decode_timing

// ==== tb/cpu8_prog_mem.sv ====
/*
 Program memory model: offers stored opcodes with operand byte and
 stack word. Assumes the decoder samples on the rising edge of mclk.
*/
`timescale 1ns/1ps
module cpu8_prog_mem (
   input  wire logic   mclk,
   input  wire logic   rst,
   input  wire logic   op_ready,
   input  wire logic   slow,
   output logic        op_valid = 1'b0,
   output logic [7:0]  op_byte = 8'h00,
   output logic [7:0]  data_byte = 8'h00,
   output logic [15:0] stack_word = 16'h0000
);
   logic [7:0]  opm [256];
   logic [7:0]  dat [256];
   logic [15:0] stk [256];
   int          n = 0;
   int          idx = 0;
   int          gap = 0;

   // ==========================================================
   // offer held until accepted; released bus shows inverted value
   always @(negedge mclk)
   begin
      if (rst || idx >= n || gap > 0)
      begin
         op_valid   <= 1'b0;
         op_byte    <= ~op_byte;
         data_byte  <= ~data_byte;
         stack_word <= ~stack_word;
      end
      else
      begin
         op_valid   <= 1'b1;
         op_byte    <= opm[idx];
         data_byte  <= dat[idx];
         stack_word <= stk[idx];
      end
   end

   always @(posedge mclk)
   begin
      if (op_valid && op_ready)
      begin
         idx <= idx + 1;
         gap <= slow ? idx % 4 : 0;
      end
      else if (gap > 0)
         gap <= gap - 1;
   end
endmodule : cpu8_prog_mem

// ==== tb/cpu8_opcode_decode_timing_bench.sv ====
/*
 Self-checking bench of the opcode decoder: random opcode stream from
 the program memory model, random register snapshots, halt cases.
 Assumes the decoder answers one cycle after each accept.
*/
`timescale 1ns/1ps
module cpu8_opcode_decode_timing_bench;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic irq_pin = 1'b0;
   logic slow = 1'b0;
   logic timed = 1'b1;
   logic op_valid, op_ready, res_valid, halted;
   logic [7:0] op_byte, data_byte;
   logic [15:0] stack_word;
   logic [127:0] rnd;
   logic [5:0] k, ck;
   cpu8_decode_pkg::cpu_regs_t cur = '0;
   cpu8_decode_pkg::decode_out_t res, ex;
   cpu8_decode_pkg::decode_out_t exq[$];
   logic [5:0] chq[$];
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;
   int last = -1;
   int due = 0;
   int seed = 32'h917e;
   int j;
   logic [7:0] corner [14] = '{8'h8E, 8'hBE, 8'h9E, 8'hE8, 8'hE0, 8'hE3,
      8'hF9, 8'h39, 8'h3B, 8'hE6, 8'hA6, 8'h17, 8'h1F, 8'hD6};
   logic [7:0] base [20] = '{8'h88, 8'h98, 8'hA0, 8'hA8, 8'hB8, 8'h09,
      8'h03, 8'h0B, 8'hC7, 8'hC0, 8'hE3, 8'hF9, 8'hD6, 8'hEE, 8'hE6,
      8'h17, 8'h1F, 8'hFB, 8'hF3, 8'h00};
   logic [7:0] msk [20] = '{8'h07, 8'h07, 8'h07, 8'h07, 8'h07, 8'h30,
      8'h30, 8'h30, 8'h38, 8'h38, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   always #5 mclk = ~mclk;

   cpu8_opcode_decode_timing cpu8_opcode_decode_timing_inst (
      .mclk(mclk), .rst(rst), .irq_pin(irq_pin), .op_valid(op_valid),
      .op_byte(op_byte), .cur(cur), .data_byte(data_byte),
      .stack_word(stack_word), .op_ready(op_ready),
      .res_valid(res_valid), .res(res), .halted(halted));

   cpu8_prog_mem cpu8_prog_mem_inst (
      .mclk(mclk), .rst(rst), .op_ready(op_ready), .slow(slow),
      .op_valid(op_valid), .op_byte(op_byte), .data_byte(data_byte),
      .stack_word(stack_word));

   // ==========================================================
   // expected result of one opcode; c selects what is compared
   function automatic cpu8_decode_pkg::decode_out_t model(
      input logic [7:0] op, input cpu8_decode_pkg::cpu_regs_t r,
      input logic [7:0] m, input logic [15:0] s, output logic [5:0] c);
      cpu8_decode_pkg::decode_out_t x;
      logic [63:0] all;
      logic [15:0] pr;
      logic [16:0] w;
      logic [8:0]  t;
      logic [7:0]  v;
      logic [3:0]  f;
      x = '0;
      x.regs = r;
      c = 6'h00;
      all = {r.acc, m, r.l, r.h, r.e, r.d, r.c, r.b};
      v = op[6] ? m : all[8 * op[2:0] +: 8];
      pr = op[5] ? (op[4] ? r.sp : {r.h, r.l})
                 : (op[4] ? {r.d, r.e} : {r.b, r.c});
      f = {r.flags[7], r.flags[2], r.flags[0], r.flags[6]};
      x.cycles = 5'h04;
      x.src = cpu8_decode_pkg::reg_sel_t'(op[2:0]);
      if (op[7:6] == 2'b10 || op == 8'hD6 || op == 8'hEE || op == 8'hE6)
      begin
         c = {5'h01, ~op[6]};
         if (op[6] || op[2:0] == 3'h6)
            x.cycles = 5'h07;
         case (op[5:3])
            3'h1: t = {1'b0, r.acc} + v + r.flags[0];
            3'h3: t = {1'b0, r.acc} - v - r.flags[0];
            3'h4: t = {1'b0, r.acc & v};
            3'h5: t = {1'b0, r.acc ^ v};
            default: t = {1'b0, r.acc} - v;
         endcase
         if (op[5:3] != 3'h7)
            x.regs.acc = t[7:0];
         x.regs.flags[0] = t[8];
      end
      else if (op == 8'h17 || op == 8'h1F)
      begin
         c = 6'h02;
         t = op[3] ? {r.acc[0], r.flags[0], r.acc[7:1]} : {r.acc, r.flags[0]};
         x.regs.acc = t[7:0];
         x.regs.flags[0] = t[8];
      end
      else if (op == 8'hE3 || op == 8'hF9)
      begin
         c = 6'h0C;
         if (op[1])
            {x.regs.h, x.regs.l} = s;
         else
            x.regs.sp = {r.h, r.l};
         x.cycles = op[1] ? 5'h10 : 5'h06;
      end
      else if ((op & 8'hCF) == 8'h09)
      begin
         c = 6'h04;
         w = {r.h, r.l} + pr;
         {x.regs.flags[0], x.regs.h, x.regs.l} = w;
         x.cycles = 5'h0A;
      end
      else if ((op & 8'hC7) == 8'h03)
      begin
         c = 6'h0C;
         pr = op[3] ? pr - 16'h0001 : pr + 16'h0001;
         case (op[5:4])
            2'h0: {x.regs.b, x.regs.c} = pr;
            2'h1: {x.regs.d, x.regs.e} = pr;
            2'h2: {x.regs.h, x.regs.l} = pr;
            default: x.regs.sp = pr;
         endcase
         x.cycles = 5'h06;
      end
      else if ((op & 8'hC7) == 8'hC7)
      begin
         c = 6'h18;
         x.regs.pc = {10'h000, op[5:3], 3'h0};
         x.regs.sp = r.sp - 16'h0002;
         x.cycles = 5'h0C;
      end
      else if ((op & 8'hC7) == 8'hC0)
      begin
         x.taken = f[op[5:4]] == op[3];
         c = x.taken ? 6'h38 : 6'h28;
         x.cycles = x.taken ? 5'h0C : 5'h06;
         if (x.taken)
         begin
            x.regs.pc = s;
            x.regs.sp = r.sp + 16'h0002;
         end
      end
      else if (op == 8'h76)
         x.cycles = 5'h05;
      return x;
   endfunction : model

   task automatic check_val(input string name, input logic [63:0] e,
                            input logic [63:0] g);
      checks_done++;
      if (g !== e)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", name, e, g);
      end
   endtask : check_val

   task automatic results;
      if (miscompares == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results

   task automatic load(input logic [7:0] o);
      cpu8_prog_mem_inst.opm[cpu8_prog_mem_inst.n] = o;
      cpu8_prog_mem_inst.dat[cpu8_prog_mem_inst.n] = 8'($random(seed));
      cpu8_prog_mem_inst.stk[cpu8_prog_mem_inst.n] = 16'($random(seed));
      cpu8_prog_mem_inst.n++;
   endtask : load

   task automatic drain;
      repeat (4000)
         if (cpu8_prog_mem_inst.idx < cpu8_prog_mem_inst.n || exq.size() > 0)
            @(negedge mclk);
   endtask : drain

   // ==========================================================
   // accept monitor, timeout and result compare
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         miscompares++;
         results();
      end
      if (op_valid && op_ready && !rst)
      begin
         exq.push_back(model(op_byte, cur, data_byte, stack_word, k));
         chq.push_back(k);
         if (timed && last >= 0)
            check_val("gap", due, cycles - last);
         last = cycles;
         due = exq[$].cycles;
      end
   end

   always @(negedge mclk)
   begin
      rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
      cur <= rnd[111:0];
      if (res_valid === 1'b1 && exq.size() > 0)
      begin
         ex = exq.pop_front();
         ck = chq.pop_front();
         check_val("cycles", ex.cycles, res.cycles);
         if (ck[0]) check_val("src", ex.src, res.src);
         if (ck[1]) check_val("acc", ex.regs.acc, res.regs.acc);
         if (ck[1]) check_val("cy", ex.regs.flags[0], res.regs.flags[0]);
         if (ck[2]) check_val("pairs", ex.regs[87:40], res.regs[87:40]);
         if (ck[3]) check_val("sp", ex.regs.sp, res.regs.sp);
         if (ck[4]) check_val("pc", ex.regs.pc, res.regs.pc);
         if (ck[5]) check_val("taken", ex.taken, res.taken);
      end
   end

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      foreach (corner[i])
         load(corner[i]);
      repeat (300)
      begin
         j = {$random(seed)} % 20;
         load(base[j] | (msk[j] & 8'($random(seed))));
      end
      drain();
      slow = 1'b1;
      timed = 1'b0;
      repeat (40)
         load(base[{$random(seed)} % 20]);
      drain();
      load(8'hFB);
      load(8'h76);
      drain();
      repeat (10) @(negedge mclk);
      check_val("halted", 1, halted);
      check_val("ready", 0, op_ready);
      irq_pin = 1'b1;
      repeat (8) @(negedge mclk);
      check_val("halted", 0, halted);
      check_val("ready", 1, op_ready);
      irq_pin = 1'b0;
      load(8'hF3);
      load(8'h76);
      drain();
      irq_pin = 1'b1;
      repeat (8) @(negedge mclk);
      check_val("halted", 1, halted);
      rst = 1'b1;
      @(negedge mclk);
      rst = 1'b0;
      irq_pin = 1'b0;
      check_val("halted", 0, halted);
      check_val("left", 0, exq.size());
      results();
   end
endmodule : cpu8_opcode_decode_timing_bench
